/* File: src/peb_regs.vh */
// Constants of the link-to-local-bus bridge and its copy engine.
// Assumes inclusion by bare name from the bridge design files.
`ifndef PEB_REGS_VH
`define PEB_REGS_VH

// Register byte offsets on APB
`define PEB_A_DMACTL 8'h04
`define PEB_A_DMASRC 8'h08
`define PEB_A_DMADST 8'h0C
`define PEB_A_DMALEN 8'h10
`define PEB_A_DMASTA 8'h14
`define PEB_A_BRCTL 8'h20
`define PEB_A_INTSTA 8'h24
`define PEB_A_INTMSK 8'h28

// Bridge control fields and the value software loads
`define PEB_BRCTL_BME 8
`define PEB_BRCTL_BAR0 16
`define PEB_BRCTL_BAR1 17
`define PEB_BRCTL_VALUE 32'h003F0107
`define PEB_BRCTL_RST 32'h00000000

// Copy engine status
`define PEB_BUSY_BIT 30
`define PEB_BUSY_MASK 32'h40000000

// Interrupt status bits
`define PEB_INT_DONE 0
`define PEB_INT_UR 1

// Inbound window translation bases
`define PEB_XLAT0 32'hFFFF0000
`define PEB_XLAT1 32'h00000000

// Packet header codes
`define PEB_TYPE_MEM 5'h00
`define PEB_TYPE_CFG0 5'h04
`define PEB_TYPE_CPL 5'h0A
`define PEB_FMT_CPLD 2'h2
`define PEB_FMT_CPL 2'h0
`define PEB_LEN_MAX 11'h400

// Configuration header register numbers
`define PEB_CFG_ID 10'h000
`define PEB_CFG_CMD 10'h001
`define PEB_CFG_BAR0L 10'h004
`define PEB_CFG_BAR0H 10'h005
`define PEB_CFG_BAR1 10'h006
`define PEB_BAR64_TYPE 4'h4
`define PEB_BAR32_TYPE 4'h0

`endif

/* File: src/peb_copy_engine.v */
// Central copy engine: moves a programmed byte count from source to destination.
// Assumes the bridge top forwards APB writes and arbitrates its local bus requests.
`timescale 1ns/1ns
module peb_copy_engine
(
	input wire mclk,
	input wire sys_rst,
	input wire regWrite,
	input wire [7:0] regAddr,
	input wire [31:0] regWdata,
	output reg [31:0] ctrl,
	output reg [31:0] srcAddr,
	output reg [31:0] dstAddr,
	output reg [31:0] lenBytes,
	output reg busy,
	output reg donePulse,
	output reg busReq,
	output reg busWe,
	output reg [31:0] busAddr,
	output reg [31:0] busWdata,
	input wire busAck,
	input wire [31:0] busRdata
);
`include "peb_regs.vh"

	reg [29:0] wordsLeft;
	reg [31:0] rdPtr;
	reg [31:0] wrPtr;

	// -----------------------------------------------------------------
	// Registers and copy sequence
	// -----------------------------------------------------------------
	always @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ctrl <= 32'h00000000;
			srcAddr <= 32'h00000000;
			dstAddr <= 32'h00000000;
			lenBytes <= 32'h00000000;
			busy <= 1'b0;
			donePulse <= 1'b0;
			busReq <= 1'b0;
			busWe <= 1'b0;
			busAddr <= 32'h00000000;
			busWdata <= 32'h00000000;
			wordsLeft <= 30'h00000000;
			rdPtr <= 32'h00000000;
			wrPtr <= 32'h00000000;
		end
		else
		begin
			donePulse <= 1'b0;
			// Register writes; address and length are locked while busy
			if (regWrite && !busy)
			begin
				case (regAddr)
					`PEB_A_DMACTL: ctrl <= regWdata;
					`PEB_A_DMASRC: srcAddr <= regWdata;
					`PEB_A_DMADST: dstAddr <= regWdata;
					`PEB_A_DMALEN:
					begin
						// Writing a nonzero length starts the copy
						lenBytes <= regWdata;
						if (regWdata != 32'h00000000)
						begin
							busy <= 1'b1;
							wordsLeft <= regWdata[31:2] + {29'h0, |regWdata[1:0]};
							rdPtr <= srcAddr + 32'h00000004;
							wrPtr <= dstAddr;
							busReq <= 1'b1;
							busWe <= 1'b0;
							busAddr <= srcAddr;
						end
					end
					default: ;
				endcase
			end
			// Alternate read at source and write at destination
			if (busy && busReq && busAck)
			begin
				if (!busWe)
				begin
					busWe <= 1'b1;
					busWdata <= busRdata;
					busAddr <= wrPtr;
					wrPtr <= wrPtr + 32'h00000004;
				end
				else if (wordsLeft == 30'h00000001)
				begin
					busReq <= 1'b0;
					busWe <= 1'b0;
					busy <= 1'b0;
					donePulse <= 1'b1;
					wordsLeft <= 30'h00000000;
				end
				else
				begin
					busWe <= 1'b0;
					busAddr <= rdPtr;
					rdPtr <= rdPtr + 32'h00000004;
					wordsLeft <= wordsLeft - 30'h00000001;
				end
			end
		end
	end
endmodule

/* File: src/peb_bridge.v */
// Endpoint bridge: inbound packets to local bus windows, config header, APB registers.
// Assumes the packet stream and APB run on mclk; local bus holds ack for one cycle.
//
// Summary of operation
// - Window hits translate to BRAM or DDR base.
// - Control value enables mastering and base windows.
// - Request length counts doublewords, zero means 1024.
// - A memory read that hits a window returns a completion with data; a miss returns none.
// - Config payload byte order swapped versus addresses.
// - Accept type-0 config read of one doubleword.
// - Engine copies from source to destination address.
// - Engine status shows busy at bit 30.
// - Nonzero length write starts copy; software waits idle.
// - Window 0 is 64-bit at registers 4 and 5.
`timescale 1ns/1ns
module peb_bridge
#(
	parameter BAR0_BITS = 16,
	parameter BAR1_BITS = 28,
	parameter [15:0] VENDOR_CODE = 16'h1234, // Arbitrary value
	parameter [15:0] DEVICE_CODE = 16'h5678 // Arbitrary value
)
(
	input wire mclk,
	input wire sys_rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire rxValid,
	input wire [31:0] rxData,
	output reg rxReady,
	output reg txValid,
	output reg [31:0] txData,
	output reg txSop,
	output reg txEop,
	input wire txReady,
	output reg locReq,
	output reg locWe,
	output reg [31:0] locAddr,
	output reg [31:0] locWdata,
	input wire locAck,
	input wire [31:0] locRdata,
	output reg irq
);
`include "peb_regs.vh"

	localparam S_IDLE = 4'd0;
	localparam S_HDR = 4'd1;
	localparam S_DISP = 4'd2;
	localparam S_WDATA = 4'd3;
	localparam S_WBUS = 4'd4;
	localparam S_CHDR = 4'd5;
	localparam S_RBUS = 4'd6;
	localparam S_RSEND = 4'd7;
	localparam S_CFGW = 4'd8;
	localparam S_DROP = 4'd9;
	localparam S_DMA = 4'd10;
	localparam [31:0] MASK0 = (32'h1 << BAR0_BITS) - 32'h1;
	localparam [31:0] MASK1 = (32'h1 << BAR1_BITS) - 32'h1;

	reg [3:0] state;
	reg [1:0] cnt;
	reg [31:0] hdr0;
	reg [31:0] hdr1;
	reg [31:0] hdr2;
	reg [31:0] hdr3;
	reg [10:0] remaining;
	reg cplData;
	reg cplCfg;
	reg [31:0] cfgWord;
	reg [31:0] brCtl;
	reg [15:0] cmd;
	reg [31:0] bar0Lo;
	reg [31:0] bar0Hi;
	reg [31:0] bar1;
	reg [1:0] intSta;
	reg [1:0] intMask;
	reg urEvent;
	wire [31:0] dmaCtrl;
	wire [31:0] dmaSrc;
	wire [31:0] dmaDst;
	wire [31:0] dmaLen;
	wire dmaBusy;
	wire dmaDone;
	wire dmaReq;
	wire dmaWe;
	wire [31:0] dmaAddr;
	wire [31:0] dmaWdata;
	wire dmaAckIn;

	// Byte reversal between config payload and register value
	function [31:0] swap32;
		input [31:0] v;
		begin
			swap32 = {v[7:0], v[15:8], v[23:16], v[31:24]};
		end
	endfunction

	// Header decode of the captured request
	wire rxTake = rxValid & rxReady;
	wire txTake = txValid & txReady;
	wire [1:0] fmt = hdr0[30:29];
	wire [4:0] typ = hdr0[28:24];
	wire [10:0] lenDw = (hdr0[9:0] == 10'h000) ? `PEB_LEN_MAX : {1'b0, hdr0[9:0]};
	wire [63:0] reqAddr = fmt[0] ? {hdr2, hdr3} : {32'h00000000, hdr2};
	wire [63:0] bar0Full = {bar0Hi, bar0Lo};
	wire [63:0] bar1Full = {32'h00000000, bar1};
	wire [9:0] cfgReg = hdr2[11:2];
	wire hit0 = brCtl[`PEB_BRCTL_BAR0] && (reqAddr[63:BAR0_BITS] == bar0Full[63:BAR0_BITS]);
	wire hit1 = brCtl[`PEB_BRCTL_BAR1] && (reqAddr[63:BAR1_BITS] == bar1Full[63:BAR1_BITS]);
	wire [31:0] xlatAddr = hit0 ? (`PEB_XLAT0 | (reqAddr[31:0] & MASK0)) :
		(`PEB_XLAT1 | (reqAddr[31:0] & MASK1));
	wire [31:0] rxSwapped = swap32(rxData); // Config payload in register order

	// Config header read value
	reg [31:0] cfgRead;
	always @*
	begin
		case (cfgReg)
			`PEB_CFG_ID: cfgRead = {DEVICE_CODE, VENDOR_CODE};
			`PEB_CFG_CMD: cfgRead = {16'h0000, cmd};
			`PEB_CFG_BAR0L: cfgRead = {bar0Lo[31:4], `PEB_BAR64_TYPE};
			`PEB_CFG_BAR0H: cfgRead = bar0Hi;
			`PEB_CFG_BAR1: cfgRead = {bar1[31:4], `PEB_BAR32_TYPE};
			default: cfgRead = 32'h00000000;
		endcase
	end

	// Completion header words
	wire [31:0] cplDw1 = {16'h0000, 4'h0, hdr0[9:0], 2'b00};
	wire [31:0] cplDw2 = {hdr1[31:16], hdr1[15:8], 1'b0, (cplCfg ? 7'h00 : reqAddr[6:0])};

	// APB access that completes in this cycle
	wire apbDone = psel & penable & pready;
	wire apbWr = apbDone & pwrite;
	wire mapped = (paddr == `PEB_A_DMACTL) || (paddr == `PEB_A_DMASRC) || (paddr == `PEB_A_DMADST) ||
		(paddr == `PEB_A_DMALEN) || (paddr == `PEB_A_DMASTA) || (paddr == `PEB_A_BRCTL) ||
		(paddr == `PEB_A_INTSTA) || (paddr == `PEB_A_INTMSK);
	assign dmaAckIn = (state == S_DMA) & locAck;

	peb_copy_engine u_copy
	(
		.mclk(mclk),
		.sys_rst(sys_rst),
		.regWrite(apbWr),
		.regAddr(paddr),
		.regWdata(pwdata),
		.ctrl(dmaCtrl),
		.srcAddr(dmaSrc),
		.dstAddr(dmaDst),
		.lenBytes(dmaLen),
		.busy(dmaBusy),
		.donePulse(dmaDone),
		.busReq(dmaReq),
		.busWe(dmaWe),
		.busAddr(dmaAddr),
		.busWdata(dmaWdata),
		.busAck(dmaAckIn),
		.busRdata(locRdata)
	);

	// -----------------------------------------------------------------
	// APB slave, control and interrupt registers
	// -----------------------------------------------------------------
	always @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
			brCtl <= `PEB_BRCTL_RST;
			intSta <= 2'b00;
			intMask <= 2'b00;
			irq <= 1'b0;
		end
		else
		begin
			// One wait state: ready on the second access cycle
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			if (psel & penable & ~pready)
			begin
				case (paddr)
					`PEB_A_DMACTL: prdata <= dmaCtrl;
					`PEB_A_DMASRC: prdata <= dmaSrc;
					`PEB_A_DMADST: prdata <= dmaDst;
					`PEB_A_DMALEN: prdata <= dmaLen;
					`PEB_A_DMASTA: prdata <= dmaBusy ? `PEB_BUSY_MASK : 32'h00000000;
					`PEB_A_BRCTL: prdata <= brCtl;
					`PEB_A_INTSTA: prdata <= {30'h0, intSta};
					`PEB_A_INTMSK: prdata <= {30'h0, intMask};
					default: prdata <= 32'h00000000;
				endcase
			end
			if (apbWr && paddr == `PEB_A_BRCTL)
				brCtl <= pwdata;
			if (apbWr && paddr == `PEB_A_INTMSK)
				intMask <= pwdata[1:0];
			// Write one clears; a same-cycle event wins
			intSta[`PEB_INT_DONE] <= dmaDone |
				(intSta[`PEB_INT_DONE] & ~(apbWr && paddr == `PEB_A_INTSTA && pwdata[`PEB_INT_DONE]));
			intSta[`PEB_INT_UR] <= urEvent |
				(intSta[`PEB_INT_UR] & ~(apbWr && paddr == `PEB_A_INTSTA && pwdata[`PEB_INT_UR]));
			irq <= |(intSta & intMask);
		end
	end

	// -----------------------------------------------------------------
	// Inbound request engine and local bus owner
	// -----------------------------------------------------------------
	always @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state <= S_IDLE;
			cnt <= 2'd0;
			hdr0 <= 32'h00000000;
			hdr1 <= 32'h00000000;
			hdr2 <= 32'h00000000;
			hdr3 <= 32'h00000000;
			remaining <= 11'h000;
			cplData <= 1'b0;
			cplCfg <= 1'b0;
			cfgWord <= 32'h00000000;
			cmd <= 16'h0000;
			bar0Lo <= 32'h00000000;
			bar0Hi <= 32'h00000000;
			bar1 <= 32'h00000000;
			urEvent <= 1'b0;
			rxReady <= 1'b0;
			txValid <= 1'b0;
			txData <= 32'h00000000;
			txSop <= 1'b0;
			txEop <= 1'b0;
			locReq <= 1'b0;
			locWe <= 1'b0;
			locAddr <= 32'h00000000;
			locWdata <= 32'h00000000;
		end
		else
		begin
			urEvent <= 1'b0;
			case (state)
				S_IDLE:
				begin
					if (rxTake)
					begin
						hdr0 <= rxData;
						cnt <= 2'd1;
						state <= S_HDR;
					end
					else if (dmaReq && brCtl[`PEB_BRCTL_BME])
					begin
						rxReady <= 1'b0;
						locReq <= 1'b1;
						locWe <= dmaWe;
						locAddr <= dmaAddr;
						locWdata <= dmaWdata;
						state <= S_DMA;
					end
					else
						rxReady <= 1'b1;
				end
				S_HDR:
				begin
					if (rxTake)
					begin
						case (cnt)
							2'd1: hdr1 <= rxData;
							2'd2: hdr2 <= rxData;
							default: hdr3 <= rxData;
						endcase
						cnt <= cnt + 2'd1;
						if (cnt == 2'd3 || (cnt == 2'd2 && !hdr0[29]))
						begin
							rxReady <= 1'b0;
							state <= S_DISP;
						end
					end
				end
				S_DISP:
				begin
					remaining <= lenDw;
					cplCfg <= 1'b0;
					cnt <= 2'd0;
					if (typ == `PEB_TYPE_CFG0 && fmt == 2'b00 && hdr0[9:0] == 10'h001)
					begin
						cplData <= 1'b1;
						cplCfg <= 1'b1;
						cfgWord <= swap32(cfgRead);
						state <= S_CHDR;
					end
					else if (typ == `PEB_TYPE_CFG0 && fmt == 2'b10 && hdr0[9:0] == 10'h001)
					begin
						rxReady <= 1'b1;
						state <= S_CFGW;
					end
					else if (typ == `PEB_TYPE_MEM && fmt[1] && (hit0 || hit1))
					begin
						locAddr <= xlatAddr;
						rxReady <= 1'b1;
						state <= S_WDATA;
					end
					else if (typ == `PEB_TYPE_MEM && !fmt[1] && (hit0 || hit1))
					begin
						cplData <= 1'b1;
						locAddr <= xlatAddr;
						state <= S_CHDR;
					end
					else
					begin
						urEvent <= 1'b1;
						rxReady <= 1'b1;
						state <= fmt[1] ? S_DROP : S_IDLE;
					end
					if (state == S_DISP && (typ != `PEB_TYPE_CFG0 || fmt != 2'b10) &&
						((typ == `PEB_TYPE_CFG0 && fmt == 2'b00 && hdr0[9:0] == 10'h001) ||
						(typ == `PEB_TYPE_MEM && !fmt[1] && (hit0 || hit1))))
					begin
						txValid <= 1'b1;
						txSop <= 1'b1;
						txData <= {1'b0, `PEB_FMT_CPLD, `PEB_TYPE_CPL, 14'h0000, hdr0[9:0]};
					end
				end
				S_CFGW:
				begin
					if (rxTake)
					begin
						// Payload arrives byte reversed against the register value
						case (cfgReg)
							`PEB_CFG_CMD: cmd <= rxSwapped[15:0];
							`PEB_CFG_BAR0L: bar0Lo <= swap32(rxData) & ~MASK0;
							`PEB_CFG_BAR0H: bar0Hi <= swap32(rxData);
							`PEB_CFG_BAR1: bar1 <= swap32(rxData) & ~MASK1;
							default: ;
						endcase
						rxReady <= 1'b0;
						cplData <= 1'b0;
						txValid <= 1'b1;
						txSop <= 1'b1;
						txData <= {1'b0, `PEB_FMT_CPL, `PEB_TYPE_CPL, 14'h0000, hdr0[9:0]};
						state <= S_CHDR;
					end
				end
				S_CHDR:
				begin
					if (txTake)
					begin
						txSop <= 1'b0;
						cnt <= cnt + 2'd1;
						if (cnt == 2'd0)
							txData <= cplDw1;
						else if (cnt == 2'd1)
						begin
							txData <= cplDw2;
							txEop <= !cplData; // Header ends a completion without data
						end
						else if (!cplData)
						begin
							txValid <= 1'b0;
							txEop <= 1'b0;
							rxReady <= 1'b1;
							state <= S_IDLE;
						end
						else if (cplCfg)
						begin
							txData <= cfgWord;
							txEop <= 1'b1;
							remaining <= 11'h001;
							state <= S_RSEND;
						end
						else
						begin
							txValid <= 1'b0;
							locReq <= 1'b1;
							locWe <= 1'b0;
							state <= S_RBUS;
						end
					end
				end
				S_RBUS:
				begin
					if (locAck)
					begin
						locReq <= 1'b0;
						txValid <= 1'b1;
						txData <= locRdata;
						txEop <= (remaining == 11'h001);
						state <= S_RSEND;
					end
				end
				S_RSEND:
				begin
					if (txTake)
					begin
						txValid <= 1'b0;
						txEop <= 1'b0;
						if (remaining == 11'h001)
						begin
							rxReady <= 1'b1;
							state <= S_IDLE;
						end
						else
						begin
							remaining <= remaining - 11'h001;
							locAddr <= locAddr + 32'h00000004;
							locReq <= 1'b1;
							state <= S_RBUS;
						end
					end
				end
				S_WDATA:
				begin
					if (rxTake)
					begin
						rxReady <= 1'b0;
						locReq <= 1'b1;
						locWe <= 1'b1;
						locWdata <= rxData;
						state <= S_WBUS;
					end
				end
				S_WBUS:
				begin
					if (locAck)
					begin
						locReq <= 1'b0;
						locWe <= 1'b0;
						locAddr <= locAddr + 32'h00000004;
						remaining <= remaining - 11'h001;
						rxReady <= 1'b1;
						state <= (remaining == 11'h001) ? S_IDLE : S_WDATA;
					end
				end
				S_DROP:
				begin
					if (rxTake)
					begin
						remaining <= remaining - 11'h001;
						if (remaining == 11'h001)
							state <= S_IDLE;
					end
				end
				S_DMA:
				begin
					if (locAck)
					begin
						locReq <= 1'b0;
						locWe <= 1'b0;
						rxReady <= 1'b1;
						state <= S_IDLE;
					end
				end
				default:
				begin
					state <= S_IDLE;
				end
			endcase
		end
	end
endmodule

/* File: dv/peb_bridge_chk.sv */
// Checker: port-level timing of the bridge top (APB, local bus, completion stream).
// Assumes a single mclk domain; bound onto peb_bridge below.
`timescale 1ns/1ns
module peb_bridge_chk
(
	input logic mclk,
	input logic sys_rst,
	input logic psel,
	input logic penable,
	input logic pready,
	input logic pslverr,
	input logic [31:0] prdata,
	input logic locReq,
	input logic locAck,
	input logic locWe,
	input logic [31:0] locAddr,
	input logic [31:0] locWdata,
	input logic rxReady,
	input logic txValid,
	input logic txReady,
	input logic [31:0] txData,
	input logic txSop,
	input logic txEop
);
default clocking cb @(posedge mclk); endclocking
default disable iff (sys_rst);
// --------------------------------
// Register bus
// --------------------------------
apb_wait_state_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
	else $error("APB answer not after one wait state");
ready_pulse_a: assert property (pready |=> !pready)
	else $error("pready held too long");
err_data_a: assert property (pslverr |-> pready && prdata == 32'h00000000)
	else $error("error answer with data");
// --------------------------------
// Local bus and packet flow
// --------------------------------
loc_hold_a: assert property (locReq && !locAck |=> locReq && $stable(locAddr) && $stable(locWe) && $stable(locWdata))
	else $error("local request changed before ack");
loc_release_a: assert property (locReq && locAck |=> !locReq)
	else $error("local request kept after ack");
rx_block_a: assert property (locReq |-> !rxReady)
	else $error("packet taken during local access");
tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txData) && $stable(txSop) && $stable(txEop))
	else $error("completion word changed while stalled");
cpl_type_a: assert property (txValid && txSop |-> txData[28:24] == 5'h0A)
	else $error("first word is not a completion header");
cpl_frame_a: assert property (txValid && txReady && txEop |=> !txValid || txSop)
	else $error("completion continues after last word");
// Main scenarios reached
cover property (pslverr);
cover property (locReq && locAck && !locWe);
cover property (txValid && txReady && txEop);
endmodule
bind peb_bridge peb_bridge_chk chk (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .prdata(prdata), .locReq(locReq), .locAck(locAck), .locWe(locWe), .locAddr(locAddr),
	.locWdata(locWdata), .rxReady(rxReady), .txValid(txValid), .txReady(txReady), .txData(txData), .txSop(txSop),
	.txEop(txEop));

/* File: dv/peb_rc_model.sv */
// Root complex model: sends queued packet words, collects completion words.
// Assumes the bench fills sendQ one packet at a time and reads gotQ.
`timescale 1ns/1ns
module peb_rc_model
(
	input wire mclk,
	input wire rxReady,
	output reg rxValid,
	output reg [31:0] rxData,
	input wire txValid,
	input wire [31:0] txData,
	input wire txSop,
	input wire txEop,
	output reg txReady
);
	logic [31:0] sendQ[$];
	logic [33:0] gotQ[$];
	initial
	begin
		rxValid = 0;
		rxData = 0;
		txReady = 0;
	end
	// Hold each word until taken; idle data toggles; random stalls on completions
	always @(posedge mclk)
	begin
		if (rxValid && rxReady)
			void'(sendQ.pop_front());
		if (txValid && txReady)
			gotQ.push_back({txSop, txEop, txData});
		txReady <= ($urandom % 4) != 0;
		rxValid <= sendQ.size() != 0;
		rxData <= sendQ.size() != 0 ? sendQ[0] : ~rxData;
	end
endmodule

/* File: dv/pcie_endpoint_bridge_with_dma_tb.sv */
// Testbench: APB setup, config and memory packets, copy engine, interrupts.
// Assumes peb_rc_model on the link side and a local memory answering here.
`timescale 1ns/1ns
module pcie_endpoint_bridge_with_dma_tb;
	reg mclk = 0, sys_rst = 1, psel, penable, pwrite, locAck, e;
	reg [7:0] paddr;
	reg [31:0] pwdata, locRdata, r, a, d;
	reg [1:0] dly = 0;
	reg [64:0] logq[$];
	wire [31:0] prdata, txData, rxData, locAddr, locWdata;
	wire pready, pslverr, rxValid, rxReady, txValid, txSop, txEop, txReady, locReq, locWe, irq;
	integer errors = 0, check_count = 0, cyc = 0, i, k, n;
	always #20 mclk = ~mclk;
	// Identity values are arbitrary
	peb_bridge #(.VENDOR_CODE(16'h0A0B), .DEVICE_CODE(16'h0C0D)) dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady), .txValid(txValid), .txData(txData),
		.txSop(txSop), .txEop(txEop), .txReady(txReady), .locReq(locReq), .locWe(locWe), .locAddr(locAddr),
		.locWdata(locWdata), .locAck(locAck), .locRdata(locRdata), .irq(irq));
	peb_rc_model rc (.mclk(mclk), .rxReady(rxReady), .rxValid(rxValid), .rxData(rxData), .txValid(txValid),
		.txData(txData), .txSop(txSop), .txEop(txEop), .txReady(txReady));
	function [31:0] sw(input [31:0] v);
		sw = {v[7:0], v[15:8], v[23:16], v[31:24]};
	endfunction
	function [31:0] mf(input [31:0] v);
		mf = v ^ 32'h5A5AC3C3;
	endfunction
	// Expected local address: window 0 answers at 6000xxxx, window 1 at 1xxxxxxx
	function [31:0] xl(input [31:0] v);
		xl = (v[31:16] == 16'h6000) ? (32'hFFFF0000 | v[15:0]) : (32'h00000000 | v[27:0]);
	endfunction
	function [31:0] h0(input [1:0] f, input [4:0] t, input [9:0] l);
		h0 = {1'b0, f, t, 14'h0, l};
	endfunction
	task ck(input [64:0] g, input [64:0] x);
		check_count = check_count + 1;
		if (g !== x)
		begin
			errors = errors + 1;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task close_out;
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// One APB transfer, released only after pready is sampled
	task apb(input w, input [7:0] ad, input [31:0] wd);
		@(posedge mclk);
		psel <= 1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1;
		@(posedge mclk);
		while (!pready) @(posedge mclk);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// Config request; payload and read data are byte reversed
	task cfg(input wr, input [9:0] rg, input [31:0] v, input [31:0] x);
		rc.gotQ.delete();
		rc.sendQ.push_back(h0({wr, 1'b0}, 5'h04, 10'h001));
		rc.sendQ.push_back(32'h0000000F);
		rc.sendQ.push_back({20'h0, rg, 2'b00});
		if (wr) rc.sendQ.push_back(sw(v));
		while (rc.gotQ.size() < (wr ? 3 : 4)) @(posedge mclk);
		ck(rc.gotQ[0][33:24], {2'b10, wr ? 8'h0A : 8'h4A});
		if (wr) ck(rc.gotQ[2][33:32], 2'b01);
		if (!wr) ck(rc.gotQ[3], {2'b01, sw(x)});
	endtask
	// Memory request of L words to window 0 or window 1
	task mem(input wr, input a64, input [31:0] ad, input [9:0] L);
		logq.delete();
		rc.gotQ.delete();
		rc.sendQ.push_back(h0({wr, a64}, 5'h00, L));
		rc.sendQ.push_back(L > 1 ? 32'h000000FF : 32'h0000000F);
		if (a64) rc.sendQ.push_back(0);
		rc.sendQ.push_back(ad);
		for (i = 0; i < L; i++) if (wr) rc.sendQ.push_back(sw(ad + 4 * i));
		while (logq.size() < L || (!wr && rc.gotQ.size() < L + 3)) @(posedge mclk);
		for (i = 0; i < L; i++)
		begin
			ck(logq[i][64:32], {wr, xl(ad + 4 * i)});
			if (wr) ck(logq[i][31:0], sw(ad + 4 * i));
			if (!wr) ck(rc.gotQ[3 + i], {1'b0, i == L - 1, mf(xl(ad + 4 * i))});
		end
		if (!wr) ck(rc.gotQ[0], {2'b10, h0(2'h2, 5'h0A, L)});
		if (!wr) ck(rc.gotQ[1][11:0], L * 4);
	endtask
	// Local memory with random answer delay; released data toggles
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			locAck <= 0;
			locRdata <= 0;
		end
		else
		begin
			locAck <= 0;
			locRdata <= ~locRdata;
			if (locReq && !locAck && dly == 0)
			begin
				locAck <= 1;
				locRdata <= mf(locAddr);
				logq.push_back({locWe, locAddr, locWdata});
				dly <= 2'($urandom);
			end
			else if (locReq && !locAck)
				dly <= dly - 1;
		end
	end
	// Hang guard
	always @(posedge mclk)
	begin
		cyc = cyc + 1;
		if (cyc == 30000)
		begin
			errors = errors + 1;
			close_out;
		end
	end
	initial
	begin
		n = $urandom(28);
		psel <= 0;
		penable <= 0;
		pwrite <= 0;
		paddr <= 0;
		pwdata <= 0;
		repeat (4) @(posedge mclk);
		sys_rst <= 0;
		@(posedge mclk);
		apb(0, 8'h20, 0); ck(r, 0);
		apb(0, 8'hFC, 0); ck({e, r}, 33'h100000000);
		apb(1, 8'h20, 32'h003F0107); apb(0, 8'h20, 0); ck(r, 32'h003F0107);
		apb(1, 8'h28, 1);
		cfg(0, 0, 0, 32'h0C0D0A0B);
		cfg(1, 4, 32'h60000000, 0);
		cfg(1, 5, 0, 0);
		cfg(0, 4, 0, 32'h60000004);
		cfg(0, 5, 0, 0);
		cfg(1, 6, 32'h10000000, 0);
		cfg(0, 6, 0, 32'h10000000);
		for (k = 0; k < 6; k++)
		begin
			a = {k[1] ? 16'h1234 : 16'h6000, 1'b0, 13'($urandom), 2'b00};
			n = 1 + $urandom % 4;
			mem(1, k[0], a, 10'(n));
			mem(0, ~k[0], a, 10'(n));
		end
		// Request outside every window: refused, masked, then raised and cleared
		logq.delete();
		rc.sendQ.push_back(h0(2'h2, 5'h00, 10'h001));
		rc.sendQ.push_back(32'h0000000F);
		rc.sendQ.push_back(32'hF0000000);
		rc.sendQ.push_back(32'h12345678);
		do apb(0, 8'h24, 0); while (r == 0);
		ck({irq, r}, 33'h2);
		apb(1, 8'h28, 3); repeat (2) @(posedge mclk); ck(irq, 1);
		apb(0, 8'h28, 0); ck(r, 3);
		apb(1, 8'h24, 2); repeat (2) @(posedge mclk); ck({irq, logq.size()}, 0);
		// Copy engine: busy shown, writes ignored while busy, words copied in order
		a = 32'hFFFF0100;
		d = 32'h00002000;
		n = 2 + $urandom % 3;
		apb(1, 8'h08, a); apb(1, 8'h0C, d); apb(1, 8'h10, n * 4);
		apb(0, 8'h14, 0); ck(r & 32'h40000000, 32'h40000000);
		apb(1, 8'h08, 0);
		do apb(0, 8'h14, 0); while (r & 32'h40000000);
		apb(0, 8'h08, 0); ck(r, a);
		apb(0, 8'h10, 0); ck(r, n * 4);
		apb(1, 8'h04, d); apb(0, 8'h04, 0); ck(r, d);
		for (i = 0; i < n; i++)
		begin
			ck(logq[2 * i][64:32], {1'b0, a + 4 * i});
			ck(logq[2 * i + 1], {1'b1, d + 4 * i, mf(a + 4 * i)});
		end
		ck(logq.size(), 2 * n);
		apb(0, 8'h24, 0); ck({irq, r}, 33'h100000001);
		// Mid-run reset returns control, status and interrupt to idle
		sys_rst <= 1;
		repeat (2) @(posedge mclk);
		sys_rst <= 0;
		@(posedge mclk);
		apb(0, 8'h20, 0); ck({irq, r}, 0);
		apb(0, 8'h24, 0); ck(r, 0);
		close_out;
	end
endmodule
